/* File: logic/edmwp_loader.sv */
// configuration loader: header, descriptor map, filter 0 image, wake pin
`timescale 1ns/1ns
`default_nettype none
module edmwp_loader
  import edmwp_pkg::*;
#(
  parameter int unsigned SHORT_CYC = PULSE_SHORT_CYC,
  parameter int unsigned LONG_CYC = PULSE_LONG_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic loadStart,
  output logic loadBusy,
  output logic loadDone,
  output logic memRdEn,
  output logic [15:0] memAddr,
  input wire logic [7:0] memRdData,
  input wire logic memRdValid,
  input wire logic [3:0] descSel,
  output logic [7:0] descLen,
  output logic [15:0] descAddr,
  output logic descPresent,
  output logic [31:0] wakeFilterConfigReg,
  output logic [127:0] wakeFilterByteMaskReg,
  output logic wakeFilterLoaded,
  input wire logic gpioWakeEvent,
  input wire logic packetWakeEvent,
  input wire logic wakeFrameFilterMatch,
  input wire logic perfectDaWakeEvent,
  input wire logic linkChangeWakeEvent,
  input wire logic wakeStatusClear,
  output logic wakeRequestPinOut,
  output logic wakeRequestPinOe,
  output logic wakeActive
);
  edmwp_ld_state_t state; // loader state
  logic [7:0] hdr [HDR_COUNT]; // header byte image
  logic [7:0] wakeFlags; // first wake flag byte
  logic [4:0] idx; // byte index within current phase
  logic [7:0] wufLen; // filter image length
  logic [15:0] wufBase; // filter image byte address
  logic [4:0] selIdx; // header index of chosen length
  edmwp_wake_if wif ();

  // header index of a byte address inside the header window
  function automatic logic [4:0] hidx(input logic [15:0] a);
    logic [15:0] d;
    d = a - HDR_FIRST;
    return d[4:0];
  endfunction

  assign wufLen = hdr[hidx(WUF_LEN_ADDR)];
  assign wufBase = {7'h00, hdr[hidx(WUF_LEN_ADDR) + 5'h01], 1'b0};

  // loader sequence: flag byte, header window, then filter image
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= LD_IDLE;
      idx <= '0;
      memRdEn <= 1'b0;
      memAddr <= '0;
      loadBusy <= 1'b0;
      loadDone <= 1'b0;
      wakeFilterLoaded <= 1'b0;
    end else begin
      memRdEn <= 1'b0;
      wakeFilterLoaded <= 1'b0;
      case (state)
        LD_IDLE: begin
          if (loadStart) begin
            state <= LD_FLAG;
            loadBusy <= 1'b1;
            loadDone <= 1'b0;
            memRdEn <= 1'b1;
            memAddr <= FLAG0_ADDR;
          end
        end
        LD_FLAG: begin
          if (memRdValid) begin
            state <= LD_HDR;
            idx <= '0;
            memRdEn <= 1'b1;
            memAddr <= HDR_FIRST;
          end
        end
        LD_HDR: begin
          // one read at a time keeps the memory side trivially simple
          if (memRdValid) begin
            if (idx == 5'(HDR_COUNT - 1)) begin
              idx <= '0;
              if (hdr[hidx(WUF_LEN_ADDR)] != 8'h00 || (hidx(WUF_LEN_ADDR) == idx && memRdData != 8'h00)) begin
                state <= LD_WUF;
                memRdEn <= 1'b1;
                memAddr <= wufBase;
              end else begin
                // absent image: filter keeps its current contents
                state <= LD_DONE;
              end
            end else begin
              idx <= idx + 5'h01;
              memRdEn <= 1'b1;
              memAddr <= HDR_FIRST + {11'h000, idx + 5'h01};
            end
          end
        end
        LD_WUF: begin
          if (memRdValid) begin
            if (idx == 5'(WUF_CFG_BYTES + WUF_MASK_BYTES - 1)) begin
              state <= LD_DONE;
              wakeFilterLoaded <= 1'b1;
            end else begin
              idx <= idx + 5'h01;
              memRdEn <= 1'b1;
              memAddr <= wufBase + {11'h000, idx + 5'h01};
            end
          end
        end
        LD_DONE: begin
          loadBusy <= 1'b0;
          loadDone <= 1'b1;
          state <= LD_IDLE;
        end
        default: state <= LD_IDLE;
      endcase
    end
  end

  // capture the flag byte and the header window
  // a reload overwrites every header byte, so no stale length survives
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wakeFlags <= 8'h00;
      for (int i = 0; i < HDR_COUNT; i++) begin
        hdr[i] <= 8'h00;
      end
    end else if (memRdValid && state == LD_FLAG) begin
      wakeFlags <= memRdData;
    end else if (memRdValid && state == LD_HDR) begin
      hdr[idx] <= memRdData;
    end
  end

  // filter image: four configuration bytes then the sixteen mask bytes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wakeFilterConfigReg <= WUF_CFG_RESET;
      wakeFilterByteMaskReg <= WUF_MASK_RESET;
    end else if (memRdValid && state == LD_WUF) begin
      if (idx < 5'(WUF_CFG_BYTES)) begin
        wakeFilterConfigReg[idx[1:0]*8 +: 8] <= memRdData;
      end else begin
        wakeFilterByteMaskReg[(idx - 5'(WUF_CFG_BYTES))*8 +: 8] <= memRdData;
      end
    end
  end

  // selector to header index of the length byte; offset follows it
  // unused selector codes fall back to the SS_DEV_ADDR pair and never report present
  always_comb begin
    case (descSel)
      SEL_SS_DEV: selIdx = hidx(SS_DEV_ADDR);
      SEL_SS_CFG: selIdx = hidx(SS_CFG_ADDR);
      SEL_HS_DEV: selIdx = hidx(HS_DEV_ADDR);
      SEL_HS_CFG: selIdx = hidx(HS_CFG_ADDR);
      SEL_FS_DEV: selIdx = hidx(FS_DEV_ADDR);
      SEL_FS_CFG: selIdx = hidx(FS_CFG_ADDR);
      SEL_SW: selIdx = hidx(SW_LEN_ADDR);
      SEL_BOS: selIdx = hidx(BOS_LEN_ADDR);
      SEL_LTM: selIdx = hidx(LTM_LEN_ADDR);
      SEL_TBUS: selIdx = hidx(TBUS_LEN_ADDR);
      default: selIdx = hidx(SS_DEV_ADDR);
    endcase
  end

  // registered lookup answer, offset turned into a byte address
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      descLen <= 8'h00;
      descAddr <= 16'h0000;
      descPresent <= 1'b0;
    end else begin
      descLen <= hdr[selIdx];
      descAddr <= {7'h00, hdr[selIdx + 5'h01], 1'b0};
      descPresent <= loadDone && (descSel <= SEL_TBUS) && hdr[selIdx] != 8'h00;
    end
  end

  // wake settings only apply once the whole load is done (loadDone)
  assign wif.enable = loadDone & wakeFlags[FLAG_EN_BIT];
  assign wif.pulseStyle = wakeFlags[FLAG_PULSE_BIT];
  assign wif.longPulse = wakeFlags[FLAG_LONG_BIT];
  assign wif.polHigh = wakeFlags[FLAG_POL_BIT];
  assign wif.pushPull = wakeFlags[FLAG_PP_BIT];
  assign wif.wakeEvent = gpioWakeEvent | packetWakeEvent | wakeFrameFilterMatch
    | perfectDaWakeEvent | linkChangeWakeEvent;
  assign wif.wakeClear = wakeStatusClear;
  assign wakeRequestPinOut = wif.pinOut;
  assign wakeRequestPinOe = wif.pinOe;
  assign wakeActive = wif.active;

  edmwp_wake_drive #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_drive (
    .ref_clk(ref_clk),
    .srst(srst),
    .w(wif.drive)
  );

  AST_WUF_NEEDS_LEN: assert property (@(posedge ref_clk) disable iff (srst)
    wakeFilterLoaded |-> wufLen != 8'h00) else $error("filter loaded with zero length");
  AST_WUF_WORD_ADDR: assert property (@(posedge ref_clk) disable iff (srst)
    memRdEn && state == LD_WUF |-> memAddr == wufBase + {11'h000, idx}) else $error("filter address not word based");
  AST_NO_WAKE_DISABLED: assert property (@(posedge ref_clk) disable iff (srst)
    !wakeFlags[FLAG_EN_BIT] |-> !wakeActive) else $error("wake asserted while disabled");

  // load sequencing and lookup answers
  AST_FLAG_READ_FIRST: assert property (@(posedge ref_clk) disable iff (srst)
    state == LD_IDLE && loadStart |=> memRdEn && memAddr == FLAG0_ADDR && loadBusy && !loadDone)
    else $error("load did not start with the flag byte");
  AST_BUSY_DONE_APART: assert property (@(posedge ref_clk) disable iff (srst)
    loadBusy |-> !loadDone) else $error("busy and done together");
  AST_ABSENT_NOT_PRESENT: assert property (@(posedge ref_clk) disable iff (srst)
    $past(hdr[selIdx]) == 8'h00 |-> !descPresent) else $error("zero length item reported present");
endmodule
`default_nettype wire

/* File: logic/edmwp_pkg.sv */
// constants and types for the configuration loader and wake request pin
package edmwp_pkg;
  // memory byte addresses of the header items
  localparam logic [15:0] FLAG0_ADDR = 16'h0009;
  localparam logic [15:0] HDR_FIRST = 16'h002F;
  localparam int unsigned HDR_COUNT = 25;
  localparam logic [15:0] BOS_LEN_ADDR = 16'h002F;
  localparam logic [15:0] BOS_OFF_ADDR = 16'h0030;
  localparam logic [15:0] SS_DEV_ADDR = 16'h0031;
  localparam logic [15:0] SS_CFG_ADDR = 16'h0033;
  localparam logic [15:0] HS_DEV_ADDR = 16'h0035;
  localparam logic [15:0] HS_CFG_ADDR = 16'h0037;
  localparam logic [15:0] FS_DEV_ADDR = 16'h0039;
  localparam logic [15:0] FS_CFG_ADDR = 16'h003B;
  localparam logic [15:0] WUF_LEN_ADDR = 16'h003D;
  localparam logic [15:0] LTM_LEN_ADDR = 16'h003F;
  localparam logic [15:0] TBUS_LEN_ADDR = 16'h0041;
  localparam logic [15:0] SW_LEN_ADDR = 16'h0046;
  localparam logic [15:0] SW_OFF_ADDR = 16'h0047;
  // descriptor selector codes on the lookup port
  localparam logic [3:0] SEL_SS_DEV = 4'h0;
  localparam logic [3:0] SEL_SS_CFG = 4'h1;
  localparam logic [3:0] SEL_HS_DEV = 4'h2;
  localparam logic [3:0] SEL_HS_CFG = 4'h3;
  localparam logic [3:0] SEL_FS_DEV = 4'h4;
  localparam logic [3:0] SEL_FS_CFG = 4'h5;
  localparam logic [3:0] SEL_SW = 4'h6;
  localparam logic [3:0] SEL_BOS = 4'h7;
  localparam logic [3:0] SEL_LTM = 4'h8;
  localparam logic [3:0] SEL_TBUS = 4'h9;
  // wake flag byte fields
  localparam int unsigned FLAG_EN_BIT = 7;
  localparam int unsigned FLAG_PULSE_BIT = 6;
  localparam int unsigned FLAG_LONG_BIT = 5;
  localparam int unsigned FLAG_POL_BIT = 4;
  localparam int unsigned FLAG_PP_BIT = 3;
  // wake frame filter image layout
  localparam int unsigned WUF_CFG_BYTES = 4;
  localparam int unsigned WUF_MASK_BYTES = 16;
  localparam logic [7:0] WUF_IMAGE_LEN = 8'h14;
  localparam logic [31:0] WUF_CFG_RESET = 32'h0000_0000;
  localparam logic [127:0] WUF_MASK_RESET = 128'h0;
  // pulse timing at the core clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PULSE_SHORT_NS = 1500000;
  localparam int unsigned PULSE_LONG_NS = 150000000;
  localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_LONG_CYC = PULSE_LONG_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W = 25;
  // loader states
  typedef enum logic [4:0] {
    LD_IDLE = 5'b00001,
    LD_FLAG = 5'b00010,
    LD_HDR = 5'b00100,
    LD_WUF = 5'b01000,
    LD_DONE = 5'b10000
  } edmwp_ld_state_t;
endpackage

/* File: logic/edmwp_wake_drive.sv */
// wake request pin driver: level or pulse, polarity and driver type
`timescale 1ns/1ns
`default_nettype none
module edmwp_wake_drive
  import edmwp_pkg::*;
#(
  parameter int unsigned SHORT_CYC = PULSE_SHORT_CYC,
  parameter int unsigned LONG_CYC = PULSE_LONG_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  edmwp_wake_if.drive w
);
  logic asserted; // wake currently signalled
  logic [PULSE_CNT_W-1:0] count; // cycles left in the pulse
  logic level; // pin level that asserted maps to

  assign level = w.polHigh ? asserted : ~asserted;
  assign w.active = asserted;

  // assertion state; pulse timed in core clock cycles
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      asserted <= 1'b0;
      count <= '0;
    end else if (!w.enable) begin
      // disabled: every other setting is don't-care
      asserted <= 1'b0;
      count <= '0;
    end else if (w.pulseStyle) begin
      if (asserted) begin
        // events during the pulse are ignored on purpose
        if (count == PULSE_CNT_W'(1)) begin
          asserted <= 1'b0;
        end
        count <= count - PULSE_CNT_W'(1);
      end else if (w.wakeEvent) begin
        asserted <= 1'b1;
        count <= w.longPulse ? PULSE_CNT_W'(LONG_CYC) : PULSE_CNT_W'(SHORT_CYC);
      end
    end else begin
      // level: set wins over a clear in the same cycle
      if (w.wakeEvent) begin
        asserted <= 1'b1;
      end else if (w.wakeClear) begin
        asserted <= 1'b0;
      end
    end
  end

  // pin flops; open drain only ever drives low
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      w.pinOut <= 1'b0;
      w.pinOe <= 1'b0;
    end else begin
      w.pinOut <= w.pushPull ? level : 1'b0;
      w.pinOe <= w.enable & (w.pushPull | ~level);
    end
  end

  sequence s_pulse_start;
    w.enable && w.pulseStyle && !asserted && w.wakeEvent;
  endsequence

  AST_DISABLED_QUIET: assert property (@(posedge ref_clk) disable iff (srst)
    !w.enable |=> !w.pinOe && !asserted) else $error("wake pin driven while disabled");
  AST_PULSE_NO_RESTART: assert property (@(posedge ref_clk) disable iff (srst)
    asserted && w.pulseStyle && w.enable && count > PULSE_CNT_W'(1) |=> count == $past(count) - PULSE_CNT_W'(1))
    else $error("pulse restarted or stalled");
  AST_PULSE_LOAD: assert property (@(posedge ref_clk) disable iff (srst)
    s_pulse_start |=> asserted && count == (w.longPulse ? PULSE_CNT_W'(LONG_CYC) : PULSE_CNT_W'(SHORT_CYC)))
    else $error("pulse length wrong");
  AST_LEVEL_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
    asserted && w.enable && !w.pulseStyle && !w.wakeClear && $stable(w.pulseStyle) |=> asserted)
    else $error("level dropped without clear");
  AST_OD_NEVER_HIGH: assert property (@(posedge ref_clk) disable iff (srst)
    w.pinOe && !$past(w.pushPull) |-> !w.pinOut) else $error("open drain drove high");
  AST_POLARITY: assert property (@(posedge ref_clk) disable iff (srst)
    $past(w.pushPull) && $past(w.enable) |-> w.pinOut == ($past(w.polHigh) ~^ $past(asserted)))
    else $error("pin polarity wrong");
endmodule
`default_nettype wire

/* File: logic/edmwp_wake_if.sv */
// wake settings passed from the loader to the pin driver, pin signals passed back
`timescale 1ns/1ns
`default_nettype none
interface edmwp_wake_if;
  logic enable; // wake signalling enabled
  logic pulseStyle; // 1 pulse, 0 level
  logic longPulse; // 1 long pulse
  logic polHigh; // 1 active high
  logic pushPull; // 1 push-pull, 0 open drain
  logic wakeEvent; // any wake source, one cycle
  logic wakeClear; // software clears level status
  logic pinOut; // pin output value
  logic pinOe; // pin output enable
  logic active; // wake asserted internally
  modport ctrl (output enable, pulseStyle, longPulse, polHigh, pushPull, wakeEvent, wakeClear,
    input pinOut, pinOe, active);
  modport drive (input enable, pulseStyle, longPulse, polHigh, pushPull, wakeEvent, wakeClear,
    output pinOut, pinOe, active);
endinterface
`default_nettype wire

/* File: test/edmwp_loader_tb.sv */
// self-checking bench for the loader and the wake request pin
`timescale 1ns/1ns
`default_nettype none
module edmwp_loader_tb;
  import edmwp_pkg::*;
  localparam int SC = 5; // shortened pulse counts keep the run brief
  localparam int LC = 20;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic loadStart = 1'b0;
  logic slow = 1'b0;
  logic clr = 1'b0;
  logic [4:0] ev = 5'h00; // one bit per wake source
  logic [3:0] descSel = 4'h0;
  logic memRdEn, memRdValid, loadBusy, loadDone, fl, pinOut, pinOe, act, descPresent;
  logic [15:0] memAddr, descAddr;
  logic [7:0] memRdData, descLen;
  logic [31:0] cfg;
  logic [127:0] msk;
  int errTotal = 0;
  int checked = 0;
  int runLen = 0; // cycles the wake has been active
  int src = 0; // rotates over the five wake sources
  logic [159:0] filtQ[$]; // expected filter images
  int lenQ[$]; // expected wake durations
  logic [15:0] hdr [10] = '{SS_DEV_ADDR, SS_CFG_ADDR, HS_DEV_ADDR, HS_CFG_ADDR, FS_DEV_ADDR, FS_CFG_ADDR,
    SW_LEN_ADDR, BOS_LEN_ADDR, LTM_LEN_ADDR, TBUS_LEN_ADDR};
  always #4 ref_clk = ~ref_clk;
  edmwp_loader #(.SHORT_CYC(SC), .LONG_CYC(LC)) DUT (.ref_clk(ref_clk), .srst(srst), .loadStart(loadStart),
    .loadBusy(loadBusy), .loadDone(loadDone), .memRdEn(memRdEn), .memAddr(memAddr), .memRdData(memRdData),
    .memRdValid(memRdValid), .descSel(descSel), .descLen(descLen), .descAddr(descAddr),
    .descPresent(descPresent), .wakeFilterConfigReg(cfg), .wakeFilterByteMaskReg(msk),
    .wakeFilterLoaded(fl), .gpioWakeEvent(ev[0]), .packetWakeEvent(ev[1]), .wakeFrameFilterMatch(ev[2]),
    .perfectDaWakeEvent(ev[3]), .linkChangeWakeEvent(ev[4]), .wakeStatusClear(clr),
    .wakeRequestPinOut(pinOut), .wakeRequestPinOe(pinOe), .wakeActive(act));
  edmwp_mem_model mem (.ref_clk(ref_clk), .slow(slow), .memRdEn(memRdEn), .memAddr(memAddr),
    .memRdData(memRdData), .memRdValid(memRdValid));
  task automatic cmp(input logic [159:0] got, input logic [159:0] exp);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmpLen(input int got, input int exp);
    checked++;
    if (got != exp) begin
      errTotal++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic giveVerdict();
    if (errTotal == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // monitor takes the oldest note when a filter load or a wake assertion ends
  always @(posedge ref_clk) begin
    if (fl === 1'b1) cmp({msk, cfg}, filtQ.size() ? filtQ.pop_front() : 160'h0);
    runLen <= (act === 1'b1) ? runLen + 1 : 0;
    if (act !== 1'b1 && runLen > 0) cmpLen(runLen, lenQ.size() ? lenQ.pop_front() : -1);
  end
  // reload with a new flag byte; the filter image is noted from the memory contents
  task automatic load(input logic [7:0] flag);
    int b;
    logic [159:0] f;
    mem.img[9] = flag;
    b = 2 * mem.img[16'h3E];
    for (int i = 0; i < 20; i++) f[8*i +: 8] = mem.img[b + i];
    // an absent image leaves the filter alone, so nothing is noted
    if (mem.img[16'h3D] != 8'h00) filtQ.push_back(f);
    @(posedge ref_clk) loadStart <= 1'b1;
    slow <= 1'($urandom);
    @(posedge ref_clk) loadStart <= 1'b0;
    @(posedge ref_clk);
    #1 cmp(loadBusy, 1'b1);
    for (int i = 0; i < 800 && loadDone !== 1'b1; i++) @(posedge ref_clk);
    #1 cmp({loadBusy, loadDone}, 2'b01);
  endtask
  // one wake event, pin sampled once it has settled
  task automatic wake(input int expLen, input logic [1:0] expPin);
    if (expLen > 0) lenQ.push_back(expLen);
    @(posedge ref_clk) ev <= 5'h01 << src;
    src = (src + 1) % 5;
    @(posedge ref_clk) ev <= 5'h00;
    repeat (2) @(posedge ref_clk);
    #1 cmp({pinOut, pinOe}, expPin);
  endtask
  initial begin
    #200000 errTotal++;
    giveVerdict();
  end
  initial begin
    int n;
    void'($urandom(32'hF0C4));
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    load(8'hD8);
    // every selector, one past the last, and the absent item
    for (int s = 0; s < 11; s++) begin
      @(posedge ref_clk) descSel <= 4'(s);
      repeat (2) @(posedge ref_clk);
      #1 cmp(descPresent, s < 10 && mem.img[hdr[s % 10]] != 0);
      if (s < 10 && mem.img[hdr[s]] != 0)
        cmp({descLen, descAddr}, {mem.img[hdr[s]], 7'h00, mem.img[hdr[s] + 1], 1'b0});
    end
    cmp({pinOut, pinOe}, 2'b01);
    wake(SC, 2'b11);
    // the extra event lands inside the pulse; the pin must be idle again on time
    wake(0, 2'b01);
    repeat (LC) @(posedge ref_clk);
    load(8'hF8);
    wake(LC, 2'b11);
    repeat (LC + 4) @(posedge ref_clk);
    load(8'h80);
    n = 2 + $urandom % 5;
    wake(n + 3, 2'b01);
    repeat (n) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk) clr <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 cmp({act, pinOe}, 2'b00);
    mem.img[16'h3D] = 8'h00; // filter image absent from here on
    load(8'h78);
    wake(0, 2'b00);
    #1 cmp(act, 1'b0);
    repeat (4) @(posedge ref_clk);
    cmp(filtQ.size(), 0);
    cmp(lenQ.size(), 0);
    giveVerdict();
  end
endmodule
`default_nettype wire

/* File: test/edmwp_mem_model.sv */
// configuration memory model answering one byte read at a time
`timescale 1ns/1ns
`default_nettype none
module edmwp_mem_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic memRdEn,
  input wire logic [15:0] memAddr,
  output logic [7:0] memRdData,
  output logic memRdValid
);
  logic [7:0] img [0:511]; // memory image, bench may rewrite the flag byte
  logic [15:0] adr; // address of the pending read
  int cnt = 0; // edges left until the answer
  // header bytes 2Fh..47h: length then word offset for each item
  logic [7:0] hdrImg [25] = '{8'h10, 8'h60, 8'h12, 8'h70, 8'h12, 8'h78, 8'h12, 8'h90, 8'h12, 8'h98,
    8'h00, 8'hA0, 8'h12, 8'hA8, 8'h14, 8'h80, 8'h18, 8'hB0, 8'h04, 8'hC0, 8'h00, 8'h02, 8'h00, 8'h0C, 8'hC8};
  // body bytes get a pattern so that swapped bytes show up
  initial begin
    for (int i = 0; i < 512; i++) img[i] = 8'(i * 7 + 3);
    for (int i = 0; i < 25; i++) img[16'h2F + i] = hdrImg[i];
    for (int i = 16'h50; i < 16'h58; i++) img[i] = 8'h00;
  end
  // answer after one edge, or three when slow; data line is not held afterwards
  always @(posedge ref_clk) begin
    memRdValid <= 1'b0;
    memRdData <= ~memRdData;
    if (memRdEn) begin
      adr <= memAddr;
      cnt <= slow ? 3 : 1;
    end else if (cnt == 1) begin
      memRdValid <= 1'b1;
      memRdData <= img[adr[8:0]];
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire
